/* rtl/bsx_pkg.sv */
// Constants and types of the branch, skip and bit execution unit
// Summary of operation
// RQ1 - Indirect call loads PC from Z, three cycles
// RQ2 - Equal operands skip next instruction, flags kept
// RQ3 - Compares subtract, set Z N V C H
// RQ4 - Skip when register bit is zero
// RQ5 - Skip when register bit is one
// RQ6 - Skip when I/O bit reads zero
// RQ7 - Skip when I/O bit reads one
// RQ8 - Branch k plus one on status bit set
// RQ9 - Branch k plus one on status bit clear
// RQ10 - Equal, not-equal, carry branches test Z, C
// RQ11 - Signed greater-or-equal branches when N xor V zero
// RQ12 - Signed less-than branches when N xor V one
// RQ13 - H, T, V, N branches test their flag
// RQ14 - Interrupt enable branches test I flag
// RQ15 - I/O bit set/clear writes bit, two cycles
// RQ16 - Rotates pass through carry, update Z C N V
// RQ17 - Bit store to T, bit load from T
// RQ18 - Dedicated flag ops force only their flag
// RQ19 - Generic flag set/clear writes bit s
// RQ20 - Skip takes two or three cycles by length
// RQ21 - Branch offset is signed two's complement
package bsx_pkg;
    localparam int PC_W = 16;
    localparam int OFS_W = 7;
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [7:0] MASK_CMP = 8'h2F;
    localparam logic [7:0] MASK_ROT = 8'h0F;
    localparam logic [7:0] STATUS_REGISTER_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
    localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
    localparam logic [PC_W-1:0] PC_SKIP_ONE = 16'h0002;
    localparam logic [PC_W-1:0] PC_SKIP_TWO = 16'h0003;
    localparam logic [1:0] CYC_SINGLE = 2'h1;
    localparam logic [1:0] CYC_INDIRECT_CALL = 2'h3;
    localparam logic [1:0] CYC_IO_BIT = 2'h2;
    localparam logic [1:0] CYC_BR_TAKEN = 2'h2;
    localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
    localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
    typedef enum logic [4:0] {
        OP_NOP    = 5'h00, OP_INDIRECT_CALL = 5'h01, OP_COMPARE_SKIP_EQUAL  = 5'h02, OP_CP   = 5'h03,
        OP_CPC    = 5'h04, OP_CPI   = 5'h05, OP_SKIP_REG_BIT_CLEAR  = 5'h06, OP_SKIP_REG_BIT_SET = 5'h07,
        OP_SKIP_IO_BIT_CLEAR   = 5'h08, OP_SKIP_IO_BIT_SET  = 5'h09, OP_BRANCH_STATUS_BIT_SET  = 5'h0A, OP_BRANCH_STATUS_BIT_CLEAR = 5'h0B,
        OP_BRANCH_SIGNED_GE   = 5'h0C, OP_BRANCH_SIGNED_LESS  = 5'h0D, OP_SETIO = 5'h0E, OP_CLRIO = 5'h0F,
        OP_ROL    = 5'h10, OP_ROR   = 5'h11, OP_BST   = 5'h12, OP_BLD  = 5'h13,
        OP_FSET   = 5'h14, OP_FCLR  = 5'h15
    } bsx_op_e;
endpackage

/* rtl/bsx_alu_if.sv */
// Operand and result bundle between the executor and its flag ALU
`timescale 1ns/1ps
interface bsx_alu_if;
    logic [7:0] op_a;
    logic [7:0] op_b;
    logic       carry_in;
    logic       rotate;
    logic       rot_right;
    logic [7:0] result;
    logic [7:0] flags;
    modport master (output op_a, op_b, carry_in, rotate, rot_right, input result, flags);
    modport alu    (input op_a, op_b, carry_in, rotate, rot_right, output result, flags);
endinterface

/* rtl/bsx_flag_alu.sv */
// Compare subtractor and rotate-through-carry unit with flag results
`timescale 1ns/1ps
module bsx_flag_alu (
    bsx_alu_if.alu alu
);
    import bsx_pkg::*;

    wire [8:0] diff  = {1'b0, alu.op_a} - {1'b0, alu.op_b} - {8'h00, alu.carry_in};
    wire [7:0] rot   = alu.rot_right ? {alu.carry_in, alu.op_a[7:1]} : {alu.op_a[6:0], alu.carry_in};
    wire       rot_c = alu.rot_right ? alu.op_a[0] : alu.op_a[7];
    wire [7:0] res   = alu.rotate ? rot : diff[7:0];
    wire       a7    = alu.op_a[7];
    wire       b7    = alu.op_b[7];
    wire       a3    = alu.op_a[3];
    wire       b3    = alu.op_b[3];
    wire       sub_v = (a7 & ~b7 & ~res[7]) | (~a7 & b7 & res[7]);
    wire       sub_h = (~a3 & b3) | (b3 & res[3]) | (res[3] & ~a3);
    wire       c_out = alu.rotate ? rot_c : diff[8];

    assign alu.result = res;

    // Only Z N V C H positions are meaningful
    always_comb begin
        alu.flags         = 8'h00;
        alu.flags[FLAG_C] = c_out;                                  // RQ16
        alu.flags[FLAG_Z] = (res == 8'h00);                         // RQ3
        alu.flags[FLAG_N] = res[7];
        alu.flags[FLAG_V] = alu.rotate ? (res[7] ^ rot_c) : sub_v;
        alu.flags[FLAG_H] = sub_h;
    end
endmodule // bsx_flag_alu

/* rtl/bsx_exec.sv */
// Executor for call, compare, skip, branch and bit instructions
`timescale 1ns/1ps
module bsx_exec (
    // Clock and reset
    input  wire logic                     CLK_I,
    input  wire logic                     SYS_RST_I,
    // Decoded instruction
    input  wire logic                     OP_VALID_I,
    input  wire bsx_pkg::bsx_op_e         OP_I,
    input  wire logic [2:0]               BIT_I,
    input  wire logic [bsx_pkg::OFS_W-1:0] OFFSET_I,
    input  wire logic [7:0]               IMM_I,
    input  wire logic [4:0]               DST_I,
    input  wire logic [4:0]               IO_ADDR_I,
    input  wire logic                     NEXT_TWO_WORD_I,
    // Operands
    input  wire logic [7:0]               RD_DATA_I,
    input  wire logic [7:0]               RR_DATA_I,
    input  wire logic [bsx_pkg::PC_W-1:0] Z_PTR_I,
    input  wire logic [7:0]               IO_RDATA_I,
    // Core state
    output logic                          READY_O,
    output logic [bsx_pkg::PC_W-1:0]      PC_O,
    output logic [7:0]                    STATUS_REGISTER_O,
    // Working register write
    output logic                          REG_WE_O,
    output logic [4:0]                    REG_ADDR_O,
    output logic [7:0]                    REG_WDATA_O,
    // I/O register write
    output logic                          IO_WE_O,
    output logic [4:0]                    IO_ADDR_O,
    output logic [7:0]                    IO_WDATA_O
);
    import bsx_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [PC_W-1:0] pc;
    logic [7:0]      status_register;
    logic [1:0]      wait_cnt;
    logic            idle;

    bsx_alu_if alu_bus ();

    bsx_flag_alu u_alu (
        .alu (alu_bus)
    );

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire accept   = OP_VALID_I & idle;
    wire is_indirect_call = (OP_I == OP_INDIRECT_CALL);
    wire is_compare_skip_equal  = (OP_I == OP_COMPARE_SKIP_EQUAL);
    wire is_cp    = (OP_I == OP_CP);
    wire is_cpc   = (OP_I == OP_CPC);
    wire is_cpi   = (OP_I == OP_CPI);
    wire is_skip_reg_bit_clear  = (OP_I == OP_SKIP_REG_BIT_CLEAR);
    wire is_skip_reg_bit_set  = (OP_I == OP_SKIP_REG_BIT_SET);
    wire is_skip_io_bit_clear  = (OP_I == OP_SKIP_IO_BIT_CLEAR);
    wire is_skip_io_bit_set  = (OP_I == OP_SKIP_IO_BIT_SET);
    wire is_branch_status_bit_set  = (OP_I == OP_BRANCH_STATUS_BIT_SET);
    wire is_branch_status_bit_clear  = (OP_I == OP_BRANCH_STATUS_BIT_CLEAR);
    wire is_branch_signed_ge  = (OP_I == OP_BRANCH_SIGNED_GE);
    wire is_branch_signed_less  = (OP_I == OP_BRANCH_SIGNED_LESS);
    wire is_setio = (OP_I == OP_SETIO);
    wire is_clrio = (OP_I == OP_CLRIO);
    wire is_rol   = (OP_I == OP_ROL);
    wire is_ror   = (OP_I == OP_ROR);
    wire is_bst   = (OP_I == OP_BST);
    wire is_bld   = (OP_I == OP_BLD);
    wire is_fset  = (OP_I == OP_FSET);
    wire is_fclr  = (OP_I == OP_FCLR);
    wire is_cmp   = is_cp | is_cpc | is_cpi;
    wire is_rot   = is_rol | is_ror;
    wire is_iobit = is_setio | is_clrio;

    // ----------------------------------------------------------------
    // Conditions
    // ----------------------------------------------------------------
    wire [7:0] bit_mask  = 8'h01 << BIT_I;
    wire       rr_bit    = RR_DATA_I[BIT_I];
    wire       io_bit    = IO_RDATA_I[BIT_I];
    wire       status_register_bit  = status_register[BIT_I];
    wire       sign_less = status_register[FLAG_N] ^ status_register[FLAG_V];

    wire skip_cond = (is_compare_skip_equal & (RD_DATA_I == RR_DATA_I))   // RQ2
                   | (is_skip_reg_bit_clear & ~rr_bit)                     // RQ4
                   | (is_skip_reg_bit_set & rr_bit)                      // RQ5
                   | (is_skip_io_bit_clear & ~io_bit)                     // RQ6
                   | (is_skip_io_bit_set & io_bit);                     // RQ7

    // Named flag branches reach here as status-bit tests with s set
    wire br_cond = (is_branch_status_bit_set & status_register_bit)                      // RQ8 RQ10 RQ13 RQ14
                 | (is_branch_status_bit_clear & ~status_register_bit)                     // RQ9
                 | (is_branch_signed_ge & ~sign_less)                    // RQ11
                 | (is_branch_signed_less & sign_less);                    // RQ12

    // ----------------------------------------------------------------
    // Program counter
    // ----------------------------------------------------------------
    wire [PC_W-1:0] off_ext   = {{(PC_W-OFS_W){OFFSET_I[OFS_W-1]}}, OFFSET_I}; // RQ21
    wire [PC_W-1:0] pc_seq    = pc + PC_STEP;
    wire [PC_W-1:0] pc_skip   = pc + (NEXT_TWO_WORD_I ? PC_SKIP_TWO : PC_SKIP_ONE);
    wire [PC_W-1:0] pc_branch = pc_seq + off_ext;

    wire [PC_W-1:0] next_pc = is_indirect_call  ? Z_PTR_I                          // RQ1
                            : skip_cond ? pc_skip
                            : br_cond   ? pc_branch
                            : pc_seq;

    // ----------------------------------------------------------------
    // Cycle count
    // ----------------------------------------------------------------
    wire [1:0] cycles = is_indirect_call  ? CYC_INDIRECT_CALL                               // RQ1
                      : is_iobit  ? CYC_IO_BIT                              // RQ15
                      : skip_cond ? (NEXT_TWO_WORD_I ? CYC_SKIP_TWO : CYC_SKIP_ONE) // RQ20
                      : br_cond   ? CYC_BR_TAKEN
                      : CYC_SINGLE;
    wire [1:0] next_wait = cycles - CYC_SINGLE;

    // ----------------------------------------------------------------
    // Flag ALU operands
    // ----------------------------------------------------------------
    assign alu_bus.op_a      = RD_DATA_I;
    assign alu_bus.op_b      = is_cpi ? IMM_I : RR_DATA_I;                  // RQ3
    assign alu_bus.carry_in  = (is_cpc | is_rot) & status_register[FLAG_C];            // RQ3 RQ16
    assign alu_bus.rotate    = is_rot;
    assign alu_bus.rot_right = is_ror;

    // ----------------------------------------------------------------
    // Status register update
    // ----------------------------------------------------------------
    wire [7:0] upd_mask = is_cmp  ? MASK_CMP                                // RQ3
                        : is_rot  ? MASK_ROT                                // RQ16
                        : is_bst  ? (8'h01 << FLAG_T)                       // RQ17
                        : (is_fset | is_fclr) ? bit_mask                    // RQ18 RQ19
                        : 8'h00;
    wire [7:0] upd_val  = (is_cmp | is_rot) ? alu_bus.flags
                        : is_bst  ? {8{rr_bit}}
                        : is_fset ? 8'hFF
                        : 8'h00;
    wire [7:0] next_status_register = (status_register & ~upd_mask) | (upd_val & upd_mask);

    // ----------------------------------------------------------------
    // Register and I/O write data
    // ----------------------------------------------------------------
    wire [7:0] bld_val  = status_register[FLAG_T] ? (RD_DATA_I | bit_mask) : (RD_DATA_I & ~bit_mask); // RQ17
    wire [7:0] reg_val  = is_rot ? alu_bus.result : bld_val;
    wire [7:0] io_val   = is_setio ? (IO_RDATA_I | bit_mask) : (IO_RDATA_I & ~bit_mask); // RQ15
    wire       reg_wr   = accept & (is_rot | is_bld);
    wire       io_wr    = accept & is_iobit;

    // ----------------------------------------------------------------
    // Sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pc       <= PC_RESET;
            status_register     <= STATUS_REGISTER_RESET;
            wait_cnt <= 2'h0;
            idle     <= 1'b1;
        end else if (accept) begin
            pc       <= next_pc;
            status_register     <= next_status_register;
            wait_cnt <= next_wait;
            idle     <= (next_wait == 2'h0);
        end else if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
            idle     <= (wait_cnt == 2'h1);
        end
    end

    // ----------------------------------------------------------------
    // Write strobes
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            REG_WE_O    <= 1'b0;
            REG_ADDR_O  <= 5'h00;
            REG_WDATA_O <= 8'h00;
            IO_WE_O     <= 1'b0;
            IO_ADDR_O   <= 5'h00;
            IO_WDATA_O  <= 8'h00;
        end else begin
            REG_WE_O    <= reg_wr;
            REG_ADDR_O  <= DST_I;
            REG_WDATA_O <= reg_val;
            IO_WE_O     <= io_wr;
            IO_ADDR_O   <= IO_ADDR_I;
            IO_WDATA_O  <= io_val;
        end
    end

    assign READY_O = idle;
    assign PC_O    = pc;
    assign STATUS_REGISTER_O  = status_register;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_indirect_call_target: assert property ( // RQ1
        @(posedge CLK_I) disable iff (SYS_RST_I)
        accept && is_indirect_call |=> (PC_O == $past(Z_PTR_I)) && !READY_O ##1 !READY_O ##1 READY_O
            && $stable(STATUS_REGISTER_O))
        else $error("indirect call target or length wrong");

    a_compare_skip_equal_skip: assert property ( // RQ2
        @(posedge CLK_I) disable iff (SYS_RST_I)
        accept && is_compare_skip_equal && (RD_DATA_I == RR_DATA_I) && NEXT_TWO_WORD_I
        |=> (PC_O == $past(PC_O) + PC_SKIP_TWO) && (STATUS_REGISTER_O == $past(STATUS_REGISTER_O)))
        else $error("compare skip did not pass two-word instruction");

    a_cmp_zero: assert property ( // RQ3
        @(posedge CLK_I) disable iff (SYS_RST_I)
        accept && is_cp |=> READY_O && (STATUS_REGISTER_O[FLAG_Z] == ($past(RD_DATA_I) == $past(RR_DATA_I)))
            && (STATUS_REGISTER_O[FLAG_C] == ($past(RD_DATA_I) < $past(RR_DATA_I))))
        else $error("compare flags wrong");

    a_skip_reg_bit_clear_skip: assert property ( // RQ4
        @(posedge CLK_I) disable iff (SYS_RST_I)
        accept && is_skip_reg_bit_clear && !rr_bit && !NEXT_TWO_WORD_I |=> PC_O == $past(PC_O) + PC_SKIP_ONE)
        else $error("clear register bit skip missed");

    a_skip_reg_bit_set_stay: assert property ( // RQ5
        @(posedge CLK_I) disable iff (SYS_RST_I)
        accept && is_skip_reg_bit_set && !rr_bit |=> READY_O && (PC_O == $past(PC_O) + PC_STEP))
        else $error("set register bit skip taken wrongly");

    a_skip_io_bit_clear_skip: assert property ( // RQ6
        @(posedge CLK_I) disable iff (SYS_RST_I)
        accept && is_skip_io_bit_clear && !io_bit |=> PC_O != $past(PC_O) + PC_STEP)
        else $error("clear io bit skip missed");

    a_skip_io_bit_set_skip: assert property ( // RQ7
        @(posedge CLK_I) disable iff (SYS_RST_I)
        accept && is_skip_io_bit_set && io_bit |=> PC_O != $past(PC_O) + PC_STEP)
        else $error("set io bit skip missed");

    a_branch_status_bit_set_taken: assert property ( // RQ8
        @(posedge CLK_I) disable iff (SYS_RST_I)
        accept && is_branch_status_bit_set && status_register_bit |=> (PC_O == $past(pc_branch)) && !READY_O ##1 READY_O)
        else $error("status set branch wrong");

    a_branch_status_bit_clear_kept: assert property ( // RQ9
        @(posedge CLK_I) disable iff (SYS_RST_I)
        accept && is_branch_status_bit_clear |=> (STATUS_REGISTER_O == $past(STATUS_REGISTER_O)) && (READY_O == $past(status_register_bit)))
        else $error("status clear branch timing wrong");

    a_signed_br: assert property ( // RQ11
        @(posedge CLK_I) disable iff (SYS_RST_I)
        accept && (is_branch_signed_ge || is_branch_signed_less) |=> (PC_O != $past(PC_O) + PC_STEP)
            == ($past(is_branch_signed_less) == $past(sign_less)))
        else $error("signed branch decision wrong");

    a_io_bit_wr: assert property ( // RQ15
        @(posedge CLK_I) disable iff (SYS_RST_I)
        accept && is_iobit |=> IO_WE_O && (IO_WDATA_O[$past(BIT_I)] == $past(is_setio)) && !READY_O
            ##1 !IO_WE_O && READY_O)
        else $error("io bit write wrong");

    a_rol_carry: assert property ( // RQ16
        @(posedge CLK_I) disable iff (SYS_RST_I)
        accept && is_rol |=> REG_WE_O && (STATUS_REGISTER_O[FLAG_C] == $past(RD_DATA_I[7]))
            && (REG_WDATA_O[0] == $past(status_register[FLAG_C])))
        else $error("rotate left through carry wrong");

    a_bst_copy: assert property ( // RQ17
        @(posedge CLK_I) disable iff (SYS_RST_I)
        accept && is_bst |=> STATUS_REGISTER_O[FLAG_T] == $past(rr_bit))
        else $error("bit store to transfer flag wrong");

    a_flag_only: assert property ( // RQ18
        @(posedge CLK_I) disable iff (SYS_RST_I)
        accept && (is_fset || is_fclr) |=> READY_O
            && (STATUS_REGISTER_O == (($past(STATUS_REGISTER_O) & ~$past(bit_mask)) | ($past(is_fset) ? $past(bit_mask) : 8'h00))))
        else $error("flag set or clear touched other bits");

    a_skip_long: assert property ( // RQ20
        @(posedge CLK_I) disable iff (SYS_RST_I)
        accept && skip_cond && NEXT_TWO_WORD_I |=> !READY_O [*2] ##1 READY_O)
        else $error("two-word skip length wrong");
endmodule // bsx_exec

/* dv/bsx_io_model.sv */
// Behavioural I/O register space seen by the executor
`timescale 1ns/1ps
module bsx_io_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Read and write access
    input  wire logic [4:0] rd_addr_i,
    input  wire logic       we_i,
    input  wire logic [4:0] wr_addr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o
);
    // ----------------------------------------
    // Storage, same-cycle read
    // ----------------------------------------
    logic [7:0] mem [32];
    assign rdata_o = mem[rd_addr_i];
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 32; i++) mem[i] <= 8'(i * 37);
        end else if (we_i) begin
            mem[wr_addr_i] <= wdata_i;
        end
    end
endmodule // bsx_io_model

/* dv/tb_bsx_exec.sv */
// Self-checking bench of the branch, skip and bit executor
`timescale 1ns/1ps
module tb_bsx_exec;
    import bsx_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic CLK_I = 0, SYS_RST_I = 1, OP_VALID_I = 0, NEXT_TWO_WORD_I = 0, READY_O, REG_WE_O, IO_WE_O;
    bsx_op_e OP_I = OP_NOP;
    logic [2:0] BIT_I = 0;
    logic [6:0] OFFSET_I = 0;
    logic [7:0] IMM_I = 0, RD_DATA_I = 0, RR_DATA_I = 0, IO_RDATA_I, STATUS_REGISTER_O, REG_WDATA_O, IO_WDATA_O;
    logic [4:0] DST_I = 0, IO_ADDR_I = 0, REG_ADDR_O, IO_ADDR_O;
    logic [15:0] Z_PTR_I = 0, PC_O;
    logic [7:0] exp_status_register, imm_v, wd, pat, ta [4], tb2 [4];
    logic [4:0] dst_v, io_v, wa;
    logic [15:0] pc, z_v, rv;
    logic we;
    int fail_count = 0, num_checks = 0, cycles = 0;
    always #5 CLK_I = ~CLK_I;
    bsx_exec i_bsx_exec (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .OP_VALID_I(OP_VALID_I), .OP_I(OP_I),
        .BIT_I(BIT_I), .OFFSET_I(OFFSET_I), .IMM_I(IMM_I), .DST_I(DST_I), .IO_ADDR_I(IO_ADDR_I),
        .NEXT_TWO_WORD_I(NEXT_TWO_WORD_I), .RD_DATA_I(RD_DATA_I), .RR_DATA_I(RR_DATA_I), .Z_PTR_I(Z_PTR_I),
        .IO_RDATA_I(IO_RDATA_I), .READY_O(READY_O), .PC_O(PC_O), .STATUS_REGISTER_O(STATUS_REGISTER_O), .REG_WE_O(REG_WE_O),
        .REG_ADDR_O(REG_ADDR_O), .REG_WDATA_O(REG_WDATA_O), .IO_WE_O(IO_WE_O), .IO_ADDR_O(IO_ADDR_O),
        .IO_WDATA_O(IO_WDATA_O));
    bsx_io_model i_bsx_io_model (.clk_i(CLK_I), .rst_i(SYS_RST_I), .rd_addr_i(IO_ADDR_I), .we_i(IO_WE_O),
        .wr_addr_i(IO_ADDR_O), .wdata_i(IO_WDATA_O), .rdata_o(IO_RDATA_I));
    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        num_checks++;
        if (seen !== expv) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask
    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            test_done();
        end
    end
    // ----------------------------------------
    // Expected flag models
    // ----------------------------------------
    function automatic logic [7:0] cmp_f(input logic [7:0] a, b, input logic ci, input logic [7:0] s);
        logic [7:0] r;
        r = a - b - 8'(ci);
        s[FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        s[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        s[FLAG_N] = r[7];
        s[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        s[FLAG_Z] = (r == 8'h00);
        return s;
    endfunction
    function automatic logic [15:0] rot_f(input logic [7:0] a, input logic rt, input logic [7:0] s);
        logic [7:0] r;
        r = rt ? {s[FLAG_C], a[7:1]} : {a[6:0], s[FLAG_C]};
        s[FLAG_C] = rt ? a[0] : a[7];
        s[FLAG_Z] = (r == 8'h00);
        s[FLAG_N] = r[7];
        s[FLAG_V] = r[7] ^ s[FLAG_C];
        return {r, s};
    endfunction
    // ----------------------------------------
    // One instruction: take, answer, cycle count
    // ----------------------------------------
    task automatic exec(input bsx_op_e op, input logic [2:0] b, input logic [6:0] k, input logic [7:0] rd,
                        input logic [7:0] rr, input logic two, input logic [15:0] pc_e, input int cyc_e);
        int cyc;
        @(posedge CLK_I);
        OP_VALID_I <= 1'b1;
        OP_I <= op;
        BIT_I <= b;
        OFFSET_I <= k;
        RD_DATA_I <= rd;
        RR_DATA_I <= rr;
        NEXT_TWO_WORD_I <= two;
        IMM_I <= imm_v;
        DST_I <= dst_v;
        IO_ADDR_I <= io_v;
        Z_PTR_I <= z_v;
        @(posedge CLK_I);
        OP_VALID_I <= 1'b0;
        #1;
        cyc = 1;
        check(PC_O, pc_e);
        check(16'(STATUS_REGISTER_O), 16'(exp_status_register));
        we = (op inside {OP_SETIO, OP_CLRIO}) ? IO_WE_O : REG_WE_O;
        wa = (op inside {OP_SETIO, OP_CLRIO}) ? IO_ADDR_O : REG_ADDR_O;
        wd = (op inside {OP_SETIO, OP_CLRIO}) ? IO_WDATA_O : REG_WDATA_O;
        while (READY_O !== 1'b1 && cyc < 8) begin
            @(posedge CLK_I);
            #1;
            cyc++;
        end
        check(16'(cyc), 16'(cyc_e));
        pc = pc_e;
    endtask
    task automatic check_wr(input logic [4:0] a, input logic [7:0] d);
        check(16'(we), 16'h0001);
        check({3'h0, wa, wd}, {3'h0, a, d});
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {imm_v, dst_v, io_v, z_v} = '0;
        ta = '{8'h10, 8'h55, 8'h80, 8'h08};
        tb2 = '{8'h20, 8'h55, 8'h01, 8'h01};
        repeat (20) @(posedge CLK_I);
        SYS_RST_I <= 1'b0;
        @(posedge CLK_I);
        #1;
        check(PC_O, PC_RESET);
        check(16'(READY_O), 16'h0001);
        check(16'(STATUS_REGISTER_O), 16'(STATUS_REGISTER_RESET));
        pc = PC_RESET;
        exp_status_register = 8'h00;
        for (int i = 0; i < 8; i++) begin
            exp_status_register[i] = 1'b1;
            exec(OP_FSET, 3'(i), 0, 0, 0, 0, pc + 16'h1, 1);
        end
        for (int i = 0; i < 8; i++) begin
            exp_status_register[i] = 1'b0;
            exec(OP_FCLR, 3'(i), 0, 0, 0, 0, pc + 16'h1, 1);
        end
        pat = 8'hA5;
        for (int i = 0; i < 8; i++) begin
            exp_status_register[i] = pat[i];
            exec(pat[i] ? OP_FSET : OP_FCLR, 3'(i), 0, 0, 0, 0, pc + 16'h1, 1);
        end
        for (int i = 0; i < 8; i++) begin
            exec(OP_BRANCH_STATUS_BIT_SET, 3'(i), 7'h7D, 0, 0, 0, pc + (pat[i] ? 16'hFFFE : 16'h1), pat[i] ? 2 : 1);
            exec(OP_BRANCH_STATUS_BIT_CLEAR, 3'(i), 7'h05, 0, 0, 0, pc + (pat[i] ? 16'h1 : 16'h6), pat[i] ? 1 : 2);
        end
        exec(OP_BRANCH_SIGNED_LESS, 0, 7'h3F, 0, 0, 0, pc + 16'h40, 2);
        exec(OP_BRANCH_SIGNED_GE, 0, 7'h3F, 0, 0, 0, pc + 16'h1, 1);
        exp_status_register[FLAG_V] = 1'b1;
        exec(OP_FSET, 3'(FLAG_V), 0, 0, 0, 0, pc + 16'h1, 1);
        exec(OP_BRANCH_SIGNED_GE, 0, 7'h40, 0, 0, 0, pc + 16'hFFC1, 2);
        exec(OP_BRANCH_SIGNED_LESS, 0, 7'h40, 0, 0, 0, pc + 16'h1, 1);
        for (int i = 0; i < 4; i++) begin
            exp_status_register = cmp_f(ta[i], tb2[i], 1'b0, exp_status_register);
            exec(OP_CP, 0, 0, ta[i], tb2[i], 0, pc + 16'h1, 1);
            exp_status_register = cmp_f(ta[i], tb2[i], exp_status_register[FLAG_C], exp_status_register);
            exec(OP_CPC, 0, 0, ta[i], tb2[i], 0, pc + 16'h1, 1);
            imm_v = tb2[i];
            exp_status_register = cmp_f(ta[i], tb2[i], 1'b0, exp_status_register);
            exec(OP_CPI, 0, 0, ta[i], ~tb2[i], 0, pc + 16'h1, 1);
        end
        dst_v = 5'h11;
        for (int i = 0; i < 4; i++) begin
            rv = rot_f(ta[i], 1'b0, exp_status_register);
            exp_status_register = rv[7:0];
            exec(OP_ROL, 0, 0, ta[i], 0, 0, pc + 16'h1, 1);
            check_wr(5'h11, rv[15:8]);
            rv = rot_f(ta[i], 1'b1, exp_status_register);
            exp_status_register = rv[7:0];
            exec(OP_ROR, 0, 0, ta[i], 0, 0, pc + 16'h1, 1);
            check_wr(5'h11, rv[15:8]);
        end
        exp_status_register[FLAG_T] = 1'b1;
        exec(OP_BST, 3'h5, 0, 0, 8'h20, 0, pc + 16'h1, 1);
        exec(OP_BLD, 3'h3, 0, 8'h00, 0, 0, pc + 16'h1, 1);
        check_wr(5'h11, 8'h08);
        exp_status_register[FLAG_T] = 1'b0;
        exec(OP_BST, 3'h5, 0, 0, 8'hDF, 0, pc + 16'h1, 1);
        exec(OP_BLD, 3'h0, 0, 8'hFF, 0, 0, pc + 16'h1, 1);
        check_wr(5'h11, 8'hFE);
        exec(OP_COMPARE_SKIP_EQUAL, 0, 0, 8'h5A, 8'h5A, 1, pc + 16'h3, 3);
        exec(OP_COMPARE_SKIP_EQUAL, 0, 0, 8'h5A, 8'h5B, 1, pc + 16'h1, 1);
        exec(OP_SKIP_REG_BIT_CLEAR, 3'h4, 0, 0, 8'hEF, 0, pc + 16'h2, 2);
        exec(OP_SKIP_REG_BIT_SET, 3'h4, 0, 0, 8'hEF, 0, pc + 16'h1, 1);
        exec(OP_SKIP_REG_BIT_SET, 3'h0, 0, 0, 8'hEF, 1, pc + 16'h3, 3);
        io_v = 5'h03;
        exec(OP_SKIP_IO_BIT_CLEAR, 3'h4, 0, 0, 0, 0, pc + 16'h2, 2);
        exec(OP_SKIP_IO_BIT_SET, 3'h4, 0, 0, 0, 0, pc + 16'h1, 1);
        exec(OP_SETIO, 3'h4, 0, 0, 0, 0, pc + 16'h1, 2);
        check_wr(5'h03, 8'h7F);
        exec(OP_SKIP_IO_BIT_SET, 3'h4, 0, 0, 0, 1, pc + 16'h3, 3);
        exec(OP_CLRIO, 3'h0, 0, 0, 0, 0, pc + 16'h1, 2);
        check_wr(5'h03, 8'h7E);
        exec(OP_SKIP_IO_BIT_CLEAR, 3'h0, 0, 0, 0, 1, pc + 16'h3, 3);
        z_v = 16'hBEEF;
        exec(OP_INDIRECT_CALL, 0, 0, 0, 0, 0, 16'hBEEF, 3);
        test_done();
    end
endmodule // tb_bsx_exec
